// >>> src/multilevel_select_key_map.vh
// constants for the staircase waveform builder
`ifndef MULTILEVEL_SELECT_KEY_MAP_VH
`define MULTILEVEL_SELECT_KEY_MAP_VH
// table geometry
`define NUM_STEPS 16
`define LAST_STEP 4'hf
`define CYCLE_LEN 11'h400
`define CNT_W 11
`define LVL_W 10
// register offsets (4-bit address)
`define REG_CTRL 4'h0
`define REG_SEL 4'h1
`define REG_COUNT 4'h2
`define REG_LEVEL 4'h3
`define REG_STATUS 4'h4
`define REG_ACTIVE 4'h5
`define REG_CONFIRM 4'h6
`define REG_SYMM 4'h7
// control bits
`define CTRL_PCT 0
`define CTRL_AUTO 1
`define CTRL_EDIT 2
`define CTRL_MULTILEVEL_SELECT_KEY 3
`define CTRL_RST 16'h0002
// confirm register bits
`define CONF_ENTER 0
`define CONF_FIELD 1
// percent scaling
`define PCT_MAX 7'h64
`define LVL_MAX 10'h1ff
`define SYMM_HALF 7'h32
// default staircase levels and lengths
`define DEF_LEN 11'h100
`define DEF_L0 10'h1ff
`define DEF_L1 10'h0ff
`define DEF_L2 10'h300
`define DEF_L3 10'h200
// dither period as a power of two of the clock
`define DITH_BIT 16
`endif

// >>> src/multilevel_select_key_fifo.v
// sample fifo: its module stands beside the builder in the principal design file

// >>> src/staircase_waveform_builder.v
// staircase waveform builder: step table, cycle assembly and playback
// How it works
// RL1 - sixteen-entry step table, each with sample count and level
// RL2 - absolute mode sample count accepts 0 to 1024
// RL3 - absolute mode level is signed 10 bits, -512 to +511
// RL4 - percent mode: count and level 0 to 100 percent, one-percent steps
// RL5 - -512 and +511 are full peaks; amplitude scaling happens downstream
// RL6 - steps concatenated from 00 upward until total reaches 1024
// RL7 - steps 00 through final contributing step are active, zero length too
// RL8 - steps above the final contributing step are inactive
// RL9 - surplus samples past 1024 discarded; stored count kept in full
// RL10 - short tables padded with level zero up to 1024
// RL11 - auto advance: count then level, then step index increments
// RL12 - auto advance off: only explicit actions move field or step
// RL13 - selected step level is dithered while editing
// RL14 - edit forces staircase on and symmetry 50, leaving restores it
// RL15 - after reset the table is a four-level quarter-cycle staircase
// RL16 - playback indexes the 1024-sample table with top ten phase bits
//
// Chosen here: the address map and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
`include "multilevel_select_key_map.vh"
module staircase_waveform_builder (
  input wire clk, // 20 MHz sample clock
  input wire rst_b, // async reset, active low
  input wire [3:0] addr, // register address
  input wire [15:0] wdata, // register write data
  input wire wr, // write strobe
  input wire rd, // read strobe
  output reg [15:0] rdata, // read data, one cycle after rd
  input wire [31:0] phase, // synthesis phase accumulator
  input wire [6:0] user_symmetry, // symmetry from the normal settings
  input wire user_multilevel_select_key_on, // staircase selected in normal use
  output wire [6:0] symmetry, // symmetry applied to the generator
  output wire multilevel_select_key_on, // staircase output enabled
  output reg [9:0] play_level, // sample at current phase
  output wire sample_valid, // fifo holds a sample
  input wire sample_ready, // playback side takes a sample
  output wire [9:0] sample_data // fifo sample
);
  // =========================================================
  // step table and controls
  reg [10:0] step_count [0:`NUM_STEPS-1];
  reg [9:0] step_level [0:`NUM_STEPS-1];
  reg [15:0] ctrl;
  reg [3:0] step_index;
  reg level_field; // 0 = entering count, 1 = entering level
  reg [15:0] dith_cnt;
  wire value_units_select = ctrl[`CTRL_PCT];
  wire auto_advance = ctrl[`CTRL_AUTO];
  wire editing = ctrl[`CTRL_EDIT];
  wire multilevel_select_key = ctrl[`CTRL_MULTILEVEL_SELECT_KEY];
  wire confirm = wr && (addr == `REG_CONFIRM) && wdata[`CONF_ENTER];
  wire [15:0] wmag = wdata[15] ? (~wdata + 16'h0001) : wdata;
  reg [10:0] next_count;
  reg [9:0] next_level;
  reg [17:0] pct_cnt;
  reg [16:0] pct_lvl;
  reg [15:0] pct_q;
  reg [16:0] lvl_q;
  // percent and absolute conversion with clamping
  always @* begin
    pct_cnt = {11'h000, wdata[6:0]} * 18'h00400; // [RL4]
    pct_lvl = {10'h000, wdata[6:0]} * 17'h001ff;
    // percent * 256 / 25 is percent of 1024 without a wide divider
    pct_q = pct_cnt[17:2] / 16'h0019;
    lvl_q = pct_lvl / 17'h00064; // percent of the positive peak
    if (value_units_select) begin
      if (wdata[6:0] > `PCT_MAX) begin
        next_count = `CYCLE_LEN;
        next_level = `LVL_MAX;
      end else begin
        next_count = pct_q[10:0]; // count*1024/100 [RL4]
        next_level = lvl_q[9:0]; // level*511/100 [RL4]
      end
    end else begin
      // clamp absolute entries to their legal ranges
      next_count = (wdata > {5'h00, `CYCLE_LEN}) ? `CYCLE_LEN : wdata[10:0]; // [RL2]
      if (!wdata[15] && (wdata > 16'h01ff)) begin
        next_level = 10'h1ff; // [RL3]
      end else if (wdata[15] && (wmag > 16'h0200)) begin
        next_level = 10'h200; // [RL3]
      end else begin
        next_level = wdata[9:0]; // [RL3]
      end
    end
  end
  // table writes; default is a four-level staircase at quarter cycles
  genvar g;
  generate
    for (g = 0; g < `NUM_STEPS; g = g + 1) begin : g_tab // [RL1]
      always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          step_count[g] <= (g < 4) ? `DEF_LEN : 11'h000; // [RL15]
          step_level[g] <= (g == 0) ? `DEF_L0 : (g == 1) ? `DEF_L1 :
                           (g == 2) ? `DEF_L2 : (g == 3) ? `DEF_L3 : 10'h000; // [RL15]
        end else if (step_index == g) begin
          if (wr && addr == `REG_COUNT) begin
            step_count[g] <= next_count;
          end
          if (wr && addr == `REG_LEVEL) begin
            step_level[g] <= next_level;
          end
        end
      end
    end
  endgenerate
  // control, selection and entry field
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= `CTRL_RST;
      step_index <= 4'h0;
      level_field <= 1'b0;
    end else begin
      if (wr && addr == `REG_CTRL) begin
        ctrl <= wdata;
      end
      if (wr && addr == `REG_SEL) begin
        step_index <= wdata[3:0]; // explicit selection [RL12]
      end else if (confirm && auto_advance && level_field) begin
        step_index <= step_index + 4'h1; // [RL11]
      end
      if (wr && addr == `REG_CONFIRM && wdata[`CONF_FIELD]) begin
        level_field <= ~level_field; // manual field switch [RL12]
      end else if (confirm && auto_advance) begin
        level_field <= ~level_field; // [RL11]
      end
    end
  end
  // =========================================================
  // edit overrides
  assign multilevel_select_key_on = editing | user_multilevel_select_key_on | multilevel_select_key; // [RL14]
  assign symmetry = editing ? `SYMM_HALF : user_symmetry; // [RL14]
  // =========================================================
  // activity: prefix sums decide the final contributing step
  reg [14:0] cum [0:`NUM_STEPS];
  reg [15:0] active;
  reg found;
  integer i;
  always @* begin
    cum[0] = 15'h0000;
    found = 1'b0;
    active = 16'h0000;
    for (i = 0; i < `NUM_STEPS; i = i + 1) begin
      cum[i+1] = cum[i] + {4'h0, step_count[i]}; // [RL6]
      active[i] = !found; // [RL7] [RL8]
      if (cum[i+1] >= {4'h0, `CYCLE_LEN}) begin
        found = 1'b1;
      end
    end
  end
  // =========================================================
  // assembly of the 1024-sample table
  localparam S_IDLE = 2'h0;
  localparam S_STEP = 2'h1;
  localparam S_PAD = 2'h2;
  reg [1:0] state;
  reg [3:0] bstep;
  reg [10:0] brem;
  reg [10:0] bpos;
  reg [9:0] wave [0:1023];
  reg dirty;
  wire [9:0] blevel;
  wire fifo_ready;
  // no write once the cycle is full, else the surplus would wrap onto sample 0
  wire bwrite = (bpos != `CYCLE_LEN) &&
                ((state == S_STEP && brem != 11'h000) || (state == S_PAD)); // [RL9]
  // dither flips bit 5 of the selected step's level [RL13]
  assign blevel = (editing && bstep == step_index && dith_cnt[`DITH_BIT-1]) ?
                  (step_level[bstep] ^ 10'h020) : step_level[bstep];
  // dither rate divider
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dith_cnt <= 16'h0000;
    end else begin
      dith_cnt <= dith_cnt + 16'h0001;
    end
  end
  // rebuild on any table change or dither toggle
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dirty <= 1'b1;
    end else if (wr || (editing && dith_cnt[`DITH_BIT-2:0] == 15'h0000)) begin
      dirty <= 1'b1;
    end else if (state == S_IDLE) begin
      dirty <= 1'b0;
    end
  end
  // sample writes into the table, stall on fifo backpressure
  always @(posedge clk) begin
    if (bwrite && fifo_ready) begin
      wave[bpos[9:0]] <= (state == S_PAD) ? 10'h000 : blevel; // [RL10]
    end
  end
  // builder state machine
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= S_IDLE;
      bstep <= 4'h0;
      brem <= 11'h000;
      bpos <= 11'h000;
    end else begin
      case (state)
        S_IDLE: begin
          if (dirty) begin
            state <= S_STEP;
            bstep <= 4'h0; // [RL6]
            brem <= step_count[0];
            bpos <= 11'h000;
          end
        end
        S_STEP: begin
          if (bpos == `CYCLE_LEN) begin
            state <= S_IDLE; // surplus dropped [RL9]
          end else if (brem == 11'h000) begin
            if (bstep == `LAST_STEP) begin
              state <= S_PAD; // [RL10]
            end else begin
              bstep <= bstep + 4'h1;
              brem <= step_count[bstep + 4'h1];
            end
          end else if (fifo_ready) begin
            brem <= brem - 11'h001;
            bpos <= bpos + 11'h001;
          end
        end
        S_PAD: begin
          if (bpos == `CYCLE_LEN) begin
            state <= S_IDLE;
          end else if (fifo_ready) begin
            bpos <= bpos + 11'h001;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end
  // built samples also stream out through the fifo
  multilevel_select_key_fifo #(.WIDTH(10), .DEPTH(32), .AW(5)) u_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .in_valid(bwrite),
    .in_ready(fifo_ready),
    .in_data((state == S_PAD) ? 10'h000 : blevel),
    .out_valid(sample_valid),
    .out_ready(sample_ready),
    .out_data(sample_data)
  );
  // =========================================================
  // playback read [RL16]; amplitude scaling is applied downstream [RL5]
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      play_level <= 10'h000;
    end else begin
      play_level <= wave[phase[31:22]]; // [RL16]
    end
  end
  // =========================================================
  // register read port
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= 16'h0000;
    end else if (rd) begin
      case (addr)
        `REG_CTRL: rdata <= ctrl;
        `REG_SEL: rdata <= {12'h000, step_index};
        `REG_COUNT: rdata <= {5'h00, step_count[step_index]}; // full length [RL9]
        `REG_LEVEL: rdata <= {{6{step_level[step_index][9]}}, step_level[step_index]};
        `REG_STATUS: rdata <= {12'h000, (state != S_IDLE), level_field,
                               active[step_index], dirty};
        `REG_ACTIVE: rdata <= active; // [RL7] [RL8]
        `REG_SYMM: rdata <= {9'h000, symmetry};
        default: rdata <= 16'h0000;
      endcase
    end
  end
endmodule // staircase_waveform_builder

// =========================================================
// synchronous fifo for the sample stream
module multilevel_select_key_fifo #(
  parameter WIDTH = 10,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  input wire clk, // sample clock
  input wire rst_b, // async reset, active low
  input wire in_valid, // write request
  output wire in_ready, // space available
  input wire [WIDTH-1:0] in_data, // write data
  output wire out_valid, // data available
  input wire out_ready, // consumer accepts
  output wire [WIDTH-1:0] out_data // read data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wptr;
  reg [AW:0] rptr;
  wire full;
  wire empty;
  // extra pointer bit distinguishes full from empty
  assign full = (wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]);
  assign empty = (wptr == rptr);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rptr[AW-1:0]];
  // storage write
  always @(posedge clk) begin
    if (in_valid && !full) begin
      mem[wptr[AW-1:0]] <= in_data;
    end
  end
  // pointers
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wptr <= {(AW+1){1'b0}};
      rptr <= {(AW+1){1'b0}};
    end else begin
      if (in_valid && !full) begin
        wptr <= wptr + 1'b1;
      end
      if (out_ready && !empty) begin
        rptr <= rptr + 1'b1;
      end
    end
  end
endmodule // multilevel_select_key_fifo
`default_nettype wire

// >>> verification/playback_model.sv
// playback side model: takes the sample stream and keeps one cycle of it
`timescale 1ns/10ps
`default_nettype none
module playback_model (
  input wire logic clk, // sample clock
  input wire logic rst_b, // async reset, active low
  input wire logic hold, // bench holds the stream off
  input wire logic sample_valid, // fifo holds a sample
  output logic sample_ready, // model takes a sample
  input wire logic [9:0] sample_data // fifo sample
);
  logic [9:0] wave [0:1023];
  logic [9:0] idx;
  logic [1:0] stall;
  // ====================
  // stream sink
  // stalls one cycle in four so the fifo never drains at full rate
  assign sample_ready = !hold && (stall != 2'h0);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      idx <= 10'h0;
      stall <= 2'h0;
    end else begin
      stall <= stall + 2'h1;
      if (sample_valid && sample_ready) begin
        wave[idx] <= sample_data; // index wraps with each 1024-sample cycle
        idx <= idx + 10'h1;
      end
    end
  end
endmodule // playback_model
`default_nettype wire

// >>> verification/builder_checker_sva.sv
// concurrent checks on the builder's ports
`timescale 1ns/10ps
`default_nettype none
module builder_checker (
  input wire logic clk, // sample clock
  input wire logic rst_b, // async reset
  input wire logic [3:0] addr, // register address
  input wire logic [15:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  input wire logic [15:0] rdata, // read data
  input wire logic [6:0] user_symmetry, // normal symmetry
  input wire logic user_multilevel_select_key_on, // normal selection
  input wire logic [6:0] symmetry, // applied symmetry
  input wire logic multilevel_select_key_on, // output enabled
  input wire logic sample_valid, // stream valid
  input wire logic sample_ready, // stream ready
  input wire logic [9:0] sample_data // stream data
);
  logic [3:0] ctrl_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ====================
  // shadow of the control bits, reset value has auto advance on
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) ctrl_q <= 4'h2;
    else if (wr && addr == 4'h0) ctrl_q <= wdata[3:0];
  end
  a_symm_edit: assert property (symmetry == (ctrl_q[2] ? 7'h32 : user_symmetry)) else $error("symmetry wrong");
  a_multilevel_select_key_force: assert property (multilevel_select_key_on == (ctrl_q[2] || ctrl_q[3] || user_multilevel_select_key_on)) else $error("multilevel_select_key_on wrong");
  a_ctrl_read: assert property (rd && addr == 4'h0 |=> rdata[3:0] == $past(ctrl_q)) else $error("ctrl read wrong");
  a_unmapped_zero: assert property (rd && addr[3] |=> rdata == 16'h0) else $error("unmapped read not zero");
  a_rdata_hold: assert property (!$past(rd) |-> $stable(rdata)) else $error("rdata moved without read");
  a_count_max: assert property (rd && addr == 4'h2 |=> rdata <= 16'h0400) else $error("count above cycle");
  a_sel_range: assert property (rd && addr == 4'h1 |=> rdata[15:4] == 12'h0) else $error("step index too wide");
  a_active_run: assert property (rd && addr == 4'h5 |=> rdata[0] && ((rdata & (rdata + 16'h1)) == 16'h0)) else $error("active mask gap");
  a_stream_hold: assert property (sample_valid && !sample_ready |=> sample_valid && $stable(sample_data)) else $error("stream dropped");
  c_edit_on: cover property (wr && addr == 4'h0 && wdata[2]);
  c_stall: cover property ((sample_valid && !sample_ready) [*8]);
  c_active_rd: cover property (rd && addr == 4'h5);
endmodule // builder_checker
`default_nettype wire

// >>> verification/test_staircase_waveform_builder.sv
// testbench for the staircase waveform builder
`timescale 1ns/10ps
`default_nettype none
`include "multilevel_select_key_map.vh"
module test_staircase_waveform_builder;
  logic clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, hold = 1'b1, user_multilevel_select_key_on = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0, rdata, rv;
  logic [31:0] phase = 32'h0;
  logic [6:0] user_symmetry = 7'h11, symmetry;
  logic multilevel_select_key_on, sample_valid, sample_ready;
  logic [9:0] play_level, sample_data;
  int err_count = 0, cmp_count = 0;
  staircase_waveform_builder i_staircase_waveform_builder (.clk, .rst_b, .addr, .wdata, .wr,
    .rd, .rdata, .phase, .user_symmetry, .user_multilevel_select_key_on, .symmetry, .multilevel_select_key_on, .play_level,
    .sample_valid, .sample_ready, .sample_data);
  playback_model i_playback_model (.clk, .rst_b, .hold, .sample_valid, .sample_ready,
    .sample_data);
  always #25 clk = ~clk;
  // ====================
  // bus tasks and comparison
  task check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_reg(input logic [3:0] a);
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 rv = rdata; // answer holds until the next read
  endtask
  task play(input logic [9:0] i, input logic [9:0] exp);
    @(posedge clk);
    phase <= {i, 22'h0};
    repeat (2) @(posedge clk);
    #1 check({6'h0, play_level}, {6'h0, exp});
  endtask
  // a rebuild is over when the busy bit drops; bounded so a hang ends the run
  task wait_idle;
    for (int n = 0; n < 3000; n++) begin
      rd_reg(`REG_STATUS);
      if (rv[3] === 1'b0 && rv[0] === 1'b0) return; // a pending rebuild is not idle
    end
    err_count++;
    wrap_up();
  endtask
  task wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ====================
  // scenarios
  task t_reset;
    rd_reg(`REG_CTRL); check(rv, `CTRL_RST);
    rd_reg(`REG_ACTIVE); check(rv, 16'h000f);
    rd_reg(`REG_COUNT); check(rv, {5'h0, `DEF_LEN});
    repeat (200) @(posedge clk); // far side stalled: fifo fills and refuses
    rd_reg(`REG_STATUS); check({15'h0, rv[3] & sample_valid}, 16'h1);
    hold <= 1'b0;
    wait_idle();
    check({6'h0, i_playback_model.wave[256]}, {6'h0, `DEF_L1});
    check({6'h0, i_playback_model.wave[768]}, {6'h0, `DEF_L3});
    play(10'h000, `DEF_L0); play(10'h0ff, `DEF_L0); play(10'h200, `DEF_L2);
    play(10'h3ff, `DEF_L3);
  endtask
  task t_truncate;
    wr_reg(`REG_COUNT, 16'h0); wr_reg(`REG_SEL, 16'h1); wr_reg(`REG_COUNT, 16'h0400);
    wait_idle();
    rd_reg(`REG_ACTIVE); check(rv, 16'h0003);
    rd_reg(`REG_COUNT); check(rv, 16'h0400);
    play(10'h000, `DEF_L1); play(10'h3ff, `DEF_L1);
    wr_reg(`REG_COUNT, 16'h07ff); rd_reg(`REG_COUNT); check(rv, 16'h0400);
  endtask
  task t_pad;
    wr_reg(`REG_COUNT, 16'h0);
    wait_idle();
    rd_reg(`REG_ACTIVE); check(rv, 16'hffff);
    play(10'h000, `DEF_L2); play(10'h258, 10'h000);
  endtask
  task t_level;
    wr_reg(`REG_SEL, 16'h2);
    wr_reg(`REG_LEVEL, 16'h7fff); rd_reg(`REG_LEVEL); check({6'h0, rv[9:0]}, 16'h01ff);
    wr_reg(`REG_LEVEL, 16'h8000); rd_reg(`REG_LEVEL); check({6'h0, rv[9:0]}, 16'h0200);
  endtask
  task t_auto;
    wr_reg(`REG_SEL, 16'h5);
    wr_reg(`REG_CONFIRM, 16'h1); rd_reg(`REG_STATUS); check({15'h0, rv[2]}, 16'h1);
    wr_reg(`REG_CONFIRM, 16'h1); rd_reg(`REG_STATUS); check({15'h0, rv[2]}, 16'h0);
    rd_reg(`REG_SEL); check(rv, 16'h6);
    wr_reg(`REG_CTRL, 16'h0);
    wr_reg(`REG_CONFIRM, 16'h1); rd_reg(`REG_SEL); check(rv, 16'h6);
    rd_reg(`REG_STATUS); check({15'h0, rv[2]}, 16'h0);
    wr_reg(`REG_CONFIRM, 16'h2); rd_reg(`REG_STATUS); check({15'h0, rv[2]}, 16'h1);
  endtask
  task t_edit;
    wr_reg(`REG_CTRL, 16'h0004);
    #1 check({8'h0, multilevel_select_key_on, symmetry}, {8'h0, 1'b1, `SYMM_HALF});
    wr_reg(`REG_CTRL, 16'h0000);
    #1 check({8'h0, multilevel_select_key_on, symmetry}, 16'h0011);
    rd_reg(4'hc); check(rv, 16'h0);
  endtask
  task t_pct;
    wr_reg(`REG_CTRL, 16'h0003); wr_reg(`REG_SEL, 16'h4);
    wr_reg(`REG_COUNT, 16'h0032); rd_reg(`REG_COUNT); check(rv, 16'h0200);
    wr_reg(`REG_LEVEL, 16'h0064); rd_reg(`REG_LEVEL); check(rv, 16'h01ff);
    wr_reg(`REG_LEVEL, 16'h0032); rd_reg(`REG_LEVEL); check(rv, 16'h00ff);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    t_reset(); t_truncate(); t_pad(); t_level(); t_auto(); t_edit(); t_pct();
    wrap_up();
  end
endmodule // test_staircase_waveform_builder
bind staircase_waveform_builder builder_checker i_builder_checker (.clk, .rst_b, .addr, .wdata,
  .wr, .rd, .rdata, .user_symmetry, .user_multilevel_select_key_on, .symmetry, .multilevel_select_key_on, .sample_valid,
  .sample_ready, .sample_data);
`default_nettype wire
